// ---- rtl/ddrdm_map.vh ----
// constants of the ddr2 data-pin block: command codes, mode bits, reset values
`ifndef DDRDM_MAP_VH
`define DDRDM_MAP_VH

// {ras_n, cas_n, we_n} codes with chip select low
`define DDRDM_CMD_LMR      3'h0
`define DDRDM_CMD_WR       3'h4
`define DDRDM_CMD_RD       3'h5

// bank code that selects the extended mode register
`define DDRDM_BA_EMR       3'h1

// extended mode register bit positions on the address pins
`define DDRDM_EMR_RTT0     2
`define DDRDM_EMR_RTT1     6
`define DDRDM_EMR_DQSC_OFF 10
`define DDRDM_EMR_RDQS_EN  11

// configuration state after reset
`define DDRDM_RST_ODT_OFF  1'b1
`define DDRDM_RST_DIFF_OFF 1'b0
`define DDRDM_RST_RDQS_ON  1'b0

// beats per burst, memory depth, width of the sampled pin bundle
`define DDRDM_BURST        3'h4
`define DDRDM_MEM_AW       6
`define DDRDM_PIN_W        46

// data lanes used by each configuration
`define DDRDM_LANES_X16    16'hffff
`define DDRDM_LANES_X8     16'h00ff
`define DDRDM_LANES_X4     16'h000f

`endif

// ---- rtl/ddrdm_mem.v ----
// small storage array with per-byte write enables and registered read data
`timescale 1ns/10ps
`include "ddrdm_map.vh"

module ddrdm_mem
(
  input  wire                      clk_sys,
  input  wire                      we,
  input  wire [1:0]                be,
  input  wire [`DDRDM_MEM_AW-1:0]  addr,
  input  wire [15:0]               wdata,
  output reg  [15:0]               rdata
);

  // ==========================================================
  // byte-lane writes and registered read
  // ==========================================================
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1)
    begin : g_lane
      reg [7:0] lane_mem [0:(1<<`DDRDM_MEM_AW)-1];
      reg [7:0] lane_q;
      // one array per lane: a masked lane keeps its byte, one writer each
      always @(posedge clk_sys)
      begin
        if (we && be[b])
          lane_mem[addr] <= wdata[b*8 +: 8];
        lane_q <= lane_mem[addr];
      end
    end
  endgenerate

  // read data lags the address by one cycle, taken from the lane registers
  always @*
  begin
    rdata = {g_lane[1].lane_q, g_lane[0].lane_q};
  end

endmodule

// ---- rtl/ddrdm_pins.v ----
// data-side pin logic of a ddr2 memory: masking, strobes, termination, commands
`timescale 1ns/10ps
`include "ddrdm_map.vh"

// What this block does
// [R01] write beat sampled with mask high leaves the stored location unchanged
// [R02] mask is sampled on both rising and falling strobe edges
// [R03] on x16 lower mask gates lower byte, upper mask the upper byte
// [R04] odt registered high on a clock edge switches termination on
// [R05] termination only on data, strobe, complement and mask pins of width
// [R06] termination disabled by load mode makes odt ignored, termination off
// [R07] command decoded from ras, cas, we with chip select at clock edge
// [R08] data bus width is sixteen, eight or four lanes per configuration
// [R09] device drives strobe with read data; controller drives it for writes
// [R10] read strobe edges coincide with read data changes
// [R11] complement strobe used only when differential mode is enabled
// [R12] x16 has one strobe pair per byte lane
// [R13] redundant read strobe exists only on x8, enabled by extended mode
// [R14] redundant strobe driven only during reads, ignored during writes
// [R15] redundant strobe disabled makes the shared pin the data mask
// [R16] redundant strobe complement needs both redundant and differential on
// [R17] control inputs sampled at rising true and falling complement clock
// [R18] chip select high masks every command; low enables the decoder
// [R19] during load mode bank pins pick the register, address carries data
// [R20] configuration bits change only when load mode is accepted
module ddrdm_pins
#(
  parameter DEV_WIDTH = 16
)
(
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        ck_t,
  input  wire        ck_c,
  input  wire        cs_n,
  input  wire        ras_n,
  input  wire        cas_n,
  input  wire        we_n,
  input  wire        odt,
  input  wire [2:0]  ba,
  input  wire [13:0] addr,
  input  wire [15:0] dq_in,
  output reg  [15:0] dq_out,
  output wire [15:0] dq_oe_n,
  input  wire        ldqs_in,
  output reg         ldqs_out,
  output wire        ldqs_oe_n,
  input  wire        ldqs_c_in,
  output reg         ldqs_c_out,
  output wire        ldqs_c_oe_n,
  input  wire        udqs_in,
  output wire        udqs_out,
  output wire        udqs_oe_n,
  input  wire        udqs_c_in,
  output wire        udqs_c_out,
  output wire        udqs_c_oe_n,
  input  wire        ldm_in,
  input  wire        udm_in,
  output wire        rdqs_out,
  output wire        rdqs_oe_n,
  output wire        rdqs_c_out,
  output wire        rdqs_c_oe_n,
  output reg  [15:0] term_dq,
  output reg         term_ldqs,
  output reg         term_ldqs_c,
  output reg         term_udqs,
  output reg         term_udqs_c,
  output reg         term_ldm,
  output reg         term_udm,
  output reg         term_rdqs_c
);

  // ==========================================================
  // configuration constants and states
  // ==========================================================
  // [R08] lanes of the bus in use for this width
  localparam [15:0] LANES = (DEV_WIDTH == 16) ? `DDRDM_LANES_X16 :
                            (DEV_WIDTH == 8)  ? `DDRDM_LANES_X8  :
                                                `DDRDM_LANES_X4;
  localparam        IS_X16 = (DEV_WIDTH == 16);
  localparam        IS_X8  = (DEV_WIDTH == 8);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WR   = 4'h2;
  localparam [3:0] ST_RPRE = 4'h4;
  localparam [3:0] ST_RDAT = 4'h8;

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  wire [`DDRDM_PIN_W-1:0] pin_raw;
  reg  [`DDRDM_PIN_W-1:0] sync1;
  reg  [`DDRDM_PIN_W-1:0] sync2;
  reg  [`DDRDM_PIN_W-1:0] sync3;
  reg  [`DDRDM_PIN_W-1:0] pin_st;

  assign pin_raw = {ck_t, ck_c, cs_n, ras_n, cas_n, we_n, odt, ba, addr,
                    ldqs_in, ldqs_c_in, udqs_in, udqs_c_in,
                    ldm_in, udm_in, dq_in};

  // three-stage chain, first stage feeds only the second
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync1 <= {`DDRDM_PIN_W{1'b0}};
      sync2 <= {`DDRDM_PIN_W{1'b0}};
      sync3 <= {`DDRDM_PIN_W{1'b0}};
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a bit changes only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < `DDRDM_PIN_W; i = i + 1)
    begin : g_stable
      always @(posedge clk_sys)
      begin
        if (sys_rst)
          pin_st[i] <= 1'b0;
        else if (sync2[i] == sync3[i])
          pin_st[i] <= sync3[i];
      end
    end
  endgenerate

  wire        ck_s;
  wire        ckc_s;
  wire        cs_s;
  wire        ras_s;
  wire        cas_s;
  wire        we_s;
  wire        odt_s;
  wire [2:0]  ba_s;
  wire [13:0] addr_s;
  wire        ldqs_s;
  wire        ldqsc_s;
  wire        udqs_s;
  wire        udqsc_s;
  wire        ldm_s;
  wire        udm_s;
  wire [15:0] dq_s;

  assign {ck_s, ckc_s, cs_s, ras_s, cas_s, we_s, odt_s, ba_s, addr_s,
          ldqs_s, ldqsc_s, udqs_s, udqsc_s, ldm_s, udm_s, dq_s} = pin_st;

  // ==========================================================
  // clock crossings and command decode
  // ==========================================================
  reg ck_phase;
  wire ck_rise;
  wire ck_fall;
  wire ck_edge;

  // [R17] rise only where true is high and complement low
  assign ck_rise = ck_s & ~ckc_s & ~ck_phase;
  assign ck_fall = ~ck_s & ckc_s & ck_phase;
  assign ck_edge = ck_rise | ck_fall;

  // phase keeps a half-crossed clock from counting twice
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      ck_phase <= 1'b0;
    else if (ck_rise)
      ck_phase <= 1'b1;
    else if (ck_fall)
      ck_phase <= 1'b0;
  end

  wire [2:0] cmd;
  wire       cmd_sel;
  wire       cmd_lmr;
  wire       cmd_wr;
  wire       cmd_rd;

  // [R07] command code from the three command pins
  assign cmd     = {ras_s, cas_s, we_s};
  // [R18] chip select high masks the decoder
  assign cmd_sel = ck_rise & ~cs_s;
  assign cmd_lmr = cmd_sel & (cmd == `DDRDM_CMD_LMR);
  assign cmd_wr  = cmd_sel & (cmd == `DDRDM_CMD_WR);
  assign cmd_rd  = cmd_sel & (cmd == `DDRDM_CMD_RD);

  // ==========================================================
  // extended mode configuration
  // ==========================================================
  reg  odt_off;
  reg  diff_off;
  reg  rdqs_on;
  wire emr_load;
  reg  next_odt_off;

  // [R19] bank pins choose the extended register
  assign emr_load = cmd_lmr & (ba_s == `DDRDM_BA_EMR);

  // both resistor-select bits low means termination disabled
  always @*
  begin
    next_odt_off = odt_off;
    if (emr_load)
      next_odt_off = ~addr_s[`DDRDM_EMR_RTT0] & ~addr_s[`DDRDM_EMR_RTT1];
  end

  // [R20] state moves only on an accepted load mode
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      odt_off  <= `DDRDM_RST_ODT_OFF;
      diff_off <= `DDRDM_RST_DIFF_OFF;
      rdqs_on  <= `DDRDM_RST_RDQS_ON;
    end
    else if (emr_load)
    begin
      odt_off  <= next_odt_off;
      diff_off <= addr_s[`DDRDM_EMR_DQSC_OFF];
      // [R13] redundant strobe only exists on x8
      rdqs_on  <= IS_X8 & addr_s[`DDRDM_EMR_RDQS_EN];
    end
  end

  // ==========================================================
  // on-die termination
  // ==========================================================
  wire term_on;

  // [R06] disabled termination ignores the odt pin
  assign term_on = odt_s & ~next_odt_off;

  // [R04] odt taken at the rising clock crossing
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      term_dq     <= 16'h0000;
      term_ldqs   <= 1'b0;
      term_ldqs_c <= 1'b0;
      term_udqs   <= 1'b0;
      term_udqs_c <= 1'b0;
      term_ldm    <= 1'b0;
      term_udm    <= 1'b0;
      term_rdqs_c <= 1'b0;
    end
    else if (ck_rise)
    begin
      // [R05] only pins present in this width
      term_dq     <= {16{term_on}} & LANES;
      term_ldqs   <= term_on;
      term_ldqs_c <= term_on;
      term_udqs   <= term_on & IS_X16;
      term_udqs_c <= term_on & IS_X16;
      term_ldm    <= term_on;
      term_udm    <= term_on & IS_X16;
      term_rdqs_c <= term_on & IS_X8;
    end
  end

  // ==========================================================
  // write strobe edges and masking
  // ==========================================================
  reg  [3:0] state;
  reg  [5:0] col;
  reg  [2:0] lbeat;
  reg  [2:0] ubeat;
  reg  [2:0] rbeat;
  reg        ldqs_prev;
  reg        udqs_prev;
  wire       ldqs_lvl;
  wire       udqs_lvl;
  wire       l_ev;
  wire       u_ev;
  wire       mask_l;
  wire       mask_u;
  wire [1:0] wr_be;
  wire [5:0] wr_addr;
  wire [5:0] rd_addr;
  wire [5:0] mem_addr;
  wire [15:0] mem_rdata;

  // [R11] in differential mode the strobe is the pair crossing
  assign ldqs_lvl = diff_off ? ldqs_s : (ldqs_s & ~ldqsc_s);
  assign udqs_lvl = diff_off ? udqs_s : (udqs_s & ~udqsc_s);

  // own read drive also shows on the pins, so prev runs always
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ldqs_prev <= 1'b0;
      udqs_prev <= 1'b0;
    end
    else
    begin
      ldqs_prev <= ldqs_lvl;
      udqs_prev <= udqs_lvl;
    end
  end

  // [R02] every strobe change, rising or falling, is a beat
  // [R12] each byte lane follows its own strobe
  assign l_ev = state[1] & (ldqs_lvl ^ ldqs_prev) & (lbeat < `DDRDM_BURST);
  assign u_ev = state[1] & IS_X16 & (udqs_lvl ^ udqs_prev) &
                (ubeat < `DDRDM_BURST);

  // [R15] shared pin is a mask only while the redundant strobe is off
  // [R14] an enabled redundant strobe is ignored during writes
  assign mask_l = ldm_s & ~rdqs_on;
  assign mask_u = udm_s;

  // [R01] masked beats count but write nothing
  // [R03] lower mask gates lane 0, upper mask lane 1
  assign wr_be   = {u_ev & ~mask_u, l_ev & ~mask_l};
  assign wr_addr = col + {4'h0, (l_ev ? lbeat[1:0] : ubeat[1:0])};
  assign rd_addr = col + {4'h0, rbeat[1:0]};
  assign mem_addr = (state[2] | state[3]) ? rd_addr : wr_addr;

  ddrdm_mem u_mem
  (
    .clk_sys (clk_sys),
    .we      (|wr_be),
    .be      (wr_be),
    .addr    (mem_addr),
    .wdata   (dq_s),
    .rdata   (mem_rdata)
  );

  // ==========================================================
  // burst sequencer
  // ==========================================================
  reg dq_drv;
  reg dqs_drv;
  wire wr_done;

  assign wr_done = (lbeat == `DDRDM_BURST) &
                   (~IS_X16 | (ubeat == `DDRDM_BURST));

  // commands other than load mode are taken only when idle
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state      <= ST_IDLE;
      col        <= 6'h00;
      lbeat      <= 3'h0;
      ubeat      <= 3'h0;
      rbeat      <= 3'h0;
      dq_out     <= 16'h0000;
      dq_drv     <= 1'b0;
      dqs_drv    <= 1'b0;
      ldqs_out   <= 1'b0;
      ldqs_c_out <= 1'b1;
    end
    else
    begin
      if (l_ev)
        lbeat <= lbeat + 3'h1;
      if (u_ev)
        ubeat <= ubeat + 3'h1;
      case (state)
        ST_IDLE:
        begin
          if (cmd_wr)
          begin
            state <= ST_WR;
            col   <= addr_s[5:0];
            lbeat <= 3'h0;
            ubeat <= 3'h0;
          end
          else if (cmd_rd)
          begin
            state <= ST_RPRE;
            col   <= addr_s[5:0];
            rbeat <= 3'h0;
          end
        end
        ST_WR:
        begin
          // [R09] controller owns the strobe; we only listen
          if (wr_done)
            state <= ST_IDLE;
        end
        ST_RPRE:
        begin
          // preamble: strobe driven low for half a clock
          if (ck_fall)
          begin
            dqs_drv    <= 1'b1;
            ldqs_out   <= 1'b0;
            ldqs_c_out <= 1'b1;
            state      <= ST_RDAT;
          end
        end
        ST_RDAT:
        begin
          if (ck_edge)
          begin
            if (rbeat < `DDRDM_BURST)
            begin
              // [R10] data and strobe change on the same cycle
              // [R09] device drives the strobe with read data
              dq_out     <= mem_rdata;
              dq_drv     <= 1'b1;
              ldqs_out   <= ~ldqs_out;
              ldqs_c_out <= ldqs_out;
              rbeat      <= rbeat + 3'h1;
            end
            else
            begin
              // last beat left the strobe low: that half is the postamble
              dq_drv  <= 1'b0;
              dqs_drv <= 1'b0;
              state   <= ST_IDLE;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // output enables and shared strobe pins
  // ==========================================================
  // [R08] only lanes of the configured width are driven
  assign dq_oe_n     = ~({16{dq_drv}} & LANES);
  assign ldqs_oe_n   = ~dqs_drv;
  // [R11] complement released unless differential mode is on
  assign ldqs_c_oe_n = ~(dqs_drv & ~diff_off);
  // [R12] upper pair mirrors the lower one, x16 only
  assign udqs_out    = ldqs_out;
  assign udqs_c_out  = ldqs_c_out;
  assign udqs_oe_n   = ~(dqs_drv & IS_X16);
  assign udqs_c_oe_n = ~(dqs_drv & IS_X16 & ~diff_off);
  // [R14] redundant strobe driven only during read bursts
  assign rdqs_out    = ldqs_out;
  assign rdqs_oe_n   = ~(dqs_drv & rdqs_on);
  // [R16] complement needs both modes enabled
  assign rdqs_c_out  = ldqs_c_out;
  assign rdqs_c_oe_n = ~(dqs_drv & rdqs_on & ~diff_off);

endmodule

// ---- bench/ddrdm_asserts.sv ----
// checker for the ddr2 data-pin block outputs
`timescale 1ns/10ps

module ddrdm_asserts
#(
  parameter DEV_WIDTH = 16
)
(
  input wire        clk_sys,
  input wire        sys_rst,
  input wire [15:0] dq_out,
  input wire [15:0] dq_oe_n,
  input wire        ldqs_out,
  input wire        ldqs_oe_n,
  input wire        ldqs_c_oe_n,
  input wire        udqs_oe_n,
  input wire        rdqs_oe_n,
  input wire [15:0] term_dq,
  input wire        term_ldqs,
  input wire        term_ldm,
  input wire        term_rdqs_c
);
  localparam [15:0] LANES = (DEV_WIDTH == 16) ? 16'hffff :
                            (DEV_WIDTH == 8) ? 16'h00ff : 16'h000f;
  reg [7:0] rd_len;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ==========
  // cycles the strobe has been driven; a burst is 5 link half-periods
  always @(posedge clk_sys)
  begin
    rd_len <= ldqs_oe_n ? 8'h00 : rd_len + 8'h01;
  end

  // ==========
  // properties
  property p_rst_idle;
    $fell(sys_rst) |-> (&dq_oe_n) && ldqs_oe_n && term_dq == 16'h0000 && !term_ldm;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
  property p_lanes;
    (dq_oe_n | LANES) == 16'hffff;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane driven beyond width");
  property p_dq_dqs;
    !dq_oe_n[0] |-> !ldqs_oe_n;
  endproperty
  a_dq_dqs: assert property (p_dq_dqs) else $error("data driven without strobe");
  property p_rd_len;
    $rose(ldqs_oe_n) |-> rd_len >= 8'h26 && rd_len <= 8'h2a;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read window wrong length");
  property p_edge;
    !ldqs_oe_n && $changed(dq_out) |-> $changed(ldqs_out);
  endproperty
  a_edge: assert property (p_edge) else $error("read data moved without strobe");
  property p_upper;
    udqs_oe_n == (ldqs_oe_n || DEV_WIDTH != 16);
  endproperty
  a_upper: assert property (p_upper) else $error("upper strobe drive wrong");
  property p_comp;
    !ldqs_c_oe_n |-> !ldqs_oe_n;
  endproperty
  a_comp: assert property (p_comp) else $error("complement driven alone");
  property p_rdqs;
    DEV_WIDTH != 8 |-> rdqs_oe_n && !term_rdqs_c;
  endproperty
  a_rdqs: assert property (p_rdqs) else $error("redundant strobe off x8");
  property p_term;
    term_ldqs == term_dq[0] && term_ldm == term_dq[0] && (term_dq & ~LANES) == 16'h0000;
  endproperty
  a_term: assert property (p_term) else $error("termination pin set uneven");
endmodule

bind ddrdm_pins ddrdm_asserts #(.DEV_WIDTH(DEV_WIDTH)) u_chk
(
  .clk_sys, .sys_rst, .dq_out, .dq_oe_n, .ldqs_out, .ldqs_oe_n, .ldqs_c_oe_n,
  .udqs_oe_n, .rdqs_oe_n, .term_dq, .term_ldqs, .term_ldm, .term_rdqs_c
);

// ---- bench/ddrdm_ctl_model.sv ----
// controller model: link clock, commands and write bursts
`timescale 1ns/10ps

module ddrdm_ctl_model
(
  output reg         ck_t,
  output wire        ck_c,
  output reg         cs_n,
  output reg         ras_n,
  output reg         cas_n,
  output reg         we_n,
  output reg  [2:0]  ba,
  output reg  [13:0] addr,
  output reg  [15:0] dq,
  output reg         dqs,
  output reg         dqs_c,
  output reg  [1:0]  dm
);
  assign ck_c = ~ck_t;

  // ==========
  // free-running link clock, phase offset from clk_sys
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {ba, addr, dq, dm} = 35'h0;
    dqs = 1'b1;
    dqs_c = 1'b0;
    ck_t = 1'b0;
    #3;
    forever #80 ck_t = ~ck_t;
  end

  // set at falling crossing, held over the rise
  task cmd(input sel_n, input [2:0] code, input [2:0] b, input [13:0] a);
  begin
    @(negedge ck_t);
    {cs_n, ras_n, cas_n, we_n} = {sel_n, code};
    ba = b;
    addr = a;
    @(negedge ck_t);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = ~ba;
    addr = ~addr;
  end
  endtask

  // strobe edges centred in each beat; released lines invert
  task wr(input sel_n, input diff, input [5:0] col, input [63:0] d, input [7:0] m);
    integer n;
  begin
    // a link edge first, so the last release and this preamble never share a step
    @(posedge ck_t);
    dqs = 1'b0;
    dqs_c = diff;
    cmd(sel_n, 3'h4, 3'h0, {8'h00, col});
    for (n = 0; n < 4; n = n + 1)
    begin
      #40;
      dq = d[16*n +: 16];
      dm = m[2*n +: 2];
      #40;
      dqs = ~dqs;
      dqs_c = diff ? ~dqs : dqs;
    end
    #40;
    dq = ~dq;
    dm = ~dm;
    dqs = ~dqs;
    dqs_c = ~dqs_c;
  end
  endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the ddr2 data-pin block
`timescale 1ns/10ps
`include "ddrdm_map.vh"

module testbench;
  reg         clk_sys, sys_rst, odt;
  integer     num_errors, n_compared, seed, i;
  reg  [15:0] ref_mem [0:63];
  reg  [7:0]  m;
  reg  [5:0]  col;
  wire        ck_t, ck_c, cs_n, ras_n, cas_n, we_n;
  wire [2:0]  ba;
  wire [13:0] addr;
  wire [15:0] c_dq, dq_in, dq_out, dq_oe_n, term_dq;
  wire [1:0]  c_dm;
  wire        c_dqs, c_dqs_c, ldqs_in, ldqs_c_in, udqs_in, udqs_c_in;
  wire        ldqs_out, ldqs_oe_n, ldqs_c_out, ldqs_c_oe_n, udqs_out, udqs_oe_n;
  wire        udqs_c_out, udqs_c_oe_n, rdqs_out, rdqs_oe_n, rdqs_c_out, rdqs_c_oe_n;
  wire        term_ldqs, term_ldqs_c, term_udqs, term_udqs_c, term_ldm, term_udm, term_rdqs_c;

  ddrdm_ctl_model u_ctl (.ck_t, .ck_c, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .dq(c_dq), .dqs(c_dqs), .dqs_c(c_dqs_c), .dm(c_dm));
  ddrdm_pins u_dut (.clk_sys, .sys_rst, .ck_t, .ck_c, .cs_n, .ras_n, .cas_n, .we_n, .odt,
    .ba, .addr, .dq_in, .dq_out, .dq_oe_n, .ldqs_in, .ldqs_out, .ldqs_oe_n, .ldqs_c_in,
    .ldqs_c_out, .ldqs_c_oe_n, .udqs_in, .udqs_out, .udqs_oe_n, .udqs_c_in, .udqs_c_out,
    .udqs_c_oe_n, .ldm_in(c_dm[0]), .udm_in(c_dm[1]), .rdqs_out, .rdqs_oe_n, .rdqs_c_out,
    .rdqs_c_oe_n, .term_dq, .term_ldqs, .term_ldqs_c, .term_udqs, .term_udqs_c, .term_ldm,
    .term_udm, .term_rdqs_c);

  // wire levels: whoever drives a pin sets it
  assign dq_in = (dq_oe_n & c_dq) | (~dq_oe_n & dq_out);
  assign ldqs_in = ldqs_oe_n ? c_dqs : ldqs_out;
  assign ldqs_c_in = ldqs_c_oe_n ? c_dqs_c : ldqs_c_out;
  assign udqs_in = udqs_oe_n ? c_dqs : udqs_out;
  assign udqs_c_in = udqs_c_oe_n ? c_dqs_c : udqs_c_out;

  // system clock
  always #5 clk_sys = ~clk_sys;

  // ==========
  // helpers
  task check(input string nm, input [15:0] seen, input [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask

  // expected word: masked byte lanes keep the old value
  function [15:0] merge(input [15:0] old, input [15:0] nw, input [1:0] mk);
  begin
    merge = {mk[1] ? old[15:8] : nw[15:8], mk[0] ? old[7:0] : nw[7:0]};
  end
  endfunction

  task wr(input s, input dif, input [5:0] c, input [7:0] mm);
    reg [63:0] dd;
    reg [5:0]  w;
    integer    n;
  begin
    dd = {$random(seed), $random(seed)};
    u_ctl.wr(s, dif, c, dd, mm);
    for (n = 0; n < 4 && !s; n = n + 1)
    begin
      w = c + n[5:0];
      ref_mem[w] = merge(ref_mem[w], dd[16*n +: 16], mm[2*n +: 2]);
    end
  end
  endtask

  // read burst, sampled 70 ns after each link crossing
  task rd(input [5:0] c, input dif);
    reg [5:0] w;
    integer   n;
  begin
    u_ctl.cmd(1'b0, `DDRDM_CMD_RD, 3'h0, {8'h00, c});
    #70;
    check("preamble", {ldqs_oe_n, ldqs_out}, 16'h0);
    for (n = 0; n < 4; n = n + 1)
    begin
      @(ck_t);
      #70;
      w = c + n[5:0];
      check("read word", dq_out, ref_mem[w]);
      check("lanes", dq_oe_n, 16'h0);
      check("strobe", ldqs_out, !n[0]);
      check("strobe pair", {udqs_out, udqs_c_out, ldqs_c_out}, {!n[0], n[0], n[0]});
      check("strobe oe", {udqs_oe_n, udqs_c_oe_n, ldqs_c_oe_n, rdqs_oe_n, rdqs_c_oe_n},
        {1'b0, !dif, !dif, 2'b11});
    end
    @(ck_t);
    #70;
    check("release", {dq_oe_n[0], ldqs_oe_n, udqs_oe_n}, 16'h7);
  end
  endtask

  task set_odt(input v);
  begin
    @(posedge clk_sys);
    #1;
    odt = v;
  end
  endtask

  task term_chk(input on);
  begin
    repeat (2) @(posedge ck_t);
    #70;
    check("term dq", term_dq, {16{on}});
    check("term pins", {term_ldqs, term_ldqs_c, term_udqs, term_udqs_c, term_ldm,
      term_udm, term_rdqs_c}, {{6{on}}, 1'b0});
  end
  endtask

  task print_verdict;
  begin
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  // ==========
  // main sequence
  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    odt = 1'b0;
    num_errors = 0;
    n_compared = 0;
    seed = 32'he973;
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    set_odt(1'b1);
    term_chk(1'b0);
    u_ctl.cmd(1'b0, `DDRDM_CMD_LMR, `DDRDM_BA_EMR, 14'h0004);
    term_chk(1'b1);
    set_odt(1'b0);
    term_chk(1'b0);
    set_odt(1'b1);
    u_ctl.cmd(1'b1, `DDRDM_CMD_LMR, `DDRDM_BA_EMR, 14'h0000);
    u_ctl.cmd(1'b0, `DDRDM_CMD_LMR, 3'h0, 14'h0000);
    term_chk(1'b1);
    u_ctl.cmd(1'b0, `DDRDM_CMD_LMR, `DDRDM_BA_EMR, 14'h0000);
    term_chk(1'b0);
    // fill, then masked and deselected writes with wrap-around corners
    for (i = 0; i < 16; i = i + 1)
      wr(1'b0, 1'b1, {i[3:0], 2'b00}, 8'h00);
    wr(1'b0, 1'b1, 6'h3e, 8'hff);
    wr(1'b0, 1'b1, 6'h3f, 8'h55);
    wr(1'b0, 1'b1, 6'h01, 8'haa);
    for (i = 0; i < 40; i = i + 1)
    begin
      col = $random(seed);
      m = $random(seed);
      wr(($random(seed) % 5) == 0, 1'b1, col, m);
    end
    for (i = 0; i < 16; i = i + 1)
      rd({i[3:0], 2'b00}, 1'b1);
    // single-ended strobes: complement carries junk
    u_ctl.cmd(1'b0, `DDRDM_CMD_LMR, `DDRDM_BA_EMR, 14'h0400);
    for (i = 0; i < 6; i = i + 1)
    begin
      col = $random(seed);
      m = $random(seed);
      wr(1'b0, 1'b0, col, m);
      rd(col, 1'b0);
    end
    print_verdict;
  end

  // watchdog: traffic needs about 60 us
  initial
  begin
    #400000;
    num_errors = num_errors + 1;
    print_verdict;
  end
endmodule
